//--- ecp_cfg.svh
`ifndef ECP_CFG_SVH
`define ECP_CFG_SVH
// Register byte offsets
`define ECP_OFF_CTRL    5'h00
`define ECP_OFF_STATE   5'h04
`define ECP_OFF_IRQ_ST  5'h08
`define ECP_OFF_IRQ_CLR 5'h0c
`define ECP_OFF_IRQ_EN  5'h10
// Control fields
`define ECP_CTRL_EN      0
`define ECP_CTRL_BUSY    1
`define ECP_CTRL_SYNC0   2
`define ECP_CTRL_SYNC1   3
`define ECP_CTRL_RST     8'h00
`define ECP_IRQ_EN_RST   7'h00
`define ECP_CMD_COUNT    7
`define ECP_STAT_COUNT   6
`endif

//--- ecp_ctrl_model.sv
`timescale 1ns/10ps
// Outside controller: idle-high command lines, one falling edge per command
module ecp_ctrl_model (
   input  wire logic       clk_i,
   output logic      [6:0] pin_o
);
   initial pin_o = 7'h7f;
   // Low for low_cyc cycles, then high for two; callers keep low_cyc at two or more so no edge is lost
   task automatic strike(input int idx, input int low_cyc);
      pin_o[idx] <= 1'b0;
      repeat (low_cyc) @(posedge clk_i);
      pin_o[idx] <= 1'b1;
      repeat (2) @(posedge clk_i);
   endtask : strike
endmodule : ecp_ctrl_model

//--- ecp_fall_detect.sv
`timescale 1ns/10ps
// Three-stage synchroniser and falling edge pulse for one pin
module ecp_fall_detect (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   output logic      fall_o
);
   logic [2:0] sync;
   logic [2:0] next_sync;
   logic       level;
   logic       next_level;

   // Level moves only once stages two and three agree, so a one-cycle glitch is ignored
   always_comb begin
      next_sync  = {sync[1:0], pin_i};
      next_level = (sync[2] == sync[1]) ? sync[2] : level;
   end

   // Idle level of the pins is high, so reset to high gives no false edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync  <= 3'h7;
         level <= 1'b1;
      end else begin
         sync  <= next_sync;
         level <= next_level;
      end
   end

   // One pulse between agreement on low and the level update; held low does not repeat
   assign fall_o = level & ~sync[2] & ~sync[1];
endmodule : ecp_fall_detect

//--- ecp_io_port.sv
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`include "ecp_cfg.svh"
module ecp_io_port
   import ecp_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic             wb_ack_o,
   output logic             irq_o,
   input  wire logic [6:0]  cmd_pin_i,
   output logic      [7:0]  stat_pin_o,
   input  wire logic        power_on_i,
   input  wire logic        output_on_i,
   input  wire logic [3:0]  limiter_act_i,
   input  wire logic        seq_active_i,
   input  wire logic [1:0]  seq_sync_i,
   output ecp_cmd_t         cmd_o
);
   //----------------------------------------
   // Input edge detection
   //----------------------------------------
   logic [6:0] fall;

   // One detector per command line
   genvar gi;
   generate
      for (gi = 0; gi < `ECP_CMD_COUNT; gi++) begin : g_in
         ecp_fall_detect u_det (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .pin_i  (cmd_pin_i[gi]),
            .fall_o (fall[gi])
         );
      end
   endgenerate

   //----------------------------------------
   // Registers and bus
   //----------------------------------------
   logic [7:0]     ctrl;
   logic [7:0]     next_ctrl;
   logic [6:0]     irq_st;
   logic [6:0]     next_irq_st;
   logic [6:0]     irq_en;
   logic [6:0]     next_irq_en;
   ecp_cmd_t       cmd;
   ecp_cmd_t       next_cmd;
   ecp_stat_t      stat;
   ecp_stat_t      next_stat;
   ecp_bus_state_t bstate;
   ecp_bus_state_t next_bstate;
   logic [31:0]    next_dat;
   logic           enabled;
   logic           wr;

   // Port enable and the write strobe of an access taken in this cycle
   assign enabled = ctrl[`ECP_CTRL_EN];
   assign wr      = (bstate == ECP_BUS_IDLE) && wb_cyc_i && wb_stb_i && wb_we_i;

   // Bus, control, command and interrupt state
   always_comb begin
      next_bstate = bstate;
      next_ctrl   = ctrl;
      next_irq_en = irq_en;
      next_dat    = wb_dat_o;
      next_cmd    = ecp_cmd_t'(enabled ? fall : 7'h00);
      next_irq_st = irq_st;
      case (bstate)
         ECP_BUS_IDLE: begin
            if (wb_cyc_i && wb_stb_i) begin
               next_bstate = ECP_BUS_ACK;
               next_dat    = 32'h0000_0000;
               if (!wb_we_i) begin
                  case (wb_adr_i)
                     `ECP_OFF_CTRL:   next_dat = {24'h00_0000, ctrl};
                     `ECP_OFF_STATE:  next_dat = {26'h000_0000, stat};
                     `ECP_OFF_IRQ_ST: next_dat = {25'h000_0000, irq_st};
                     `ECP_OFF_IRQ_EN: next_dat = {25'h000_0000, irq_en};
                     default:         next_dat = 32'h0000_0000;
                  endcase
               end else if (wr && wb_sel_i[0]) begin
                  case (wb_adr_i)
                     `ECP_OFF_CTRL:    next_ctrl   = wb_dat_i[7:0];
                     `ECP_OFF_IRQ_CLR: next_irq_st = irq_st & ~wb_dat_i[6:0];
                     `ECP_OFF_IRQ_EN:  next_irq_en = wb_dat_i[6:0];
                     default:          next_ctrl   = ctrl;
                  endcase
               end
            end
         end
         ECP_BUS_ACK: begin
            next_bstate = ECP_BUS_IDLE;
         end
         default: begin
            next_bstate = ECP_BUS_IDLE;
         end
      endcase
      // Set wins over a clear in the same cycle
      next_irq_st = next_irq_st | next_cmd;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bstate   <= ECP_BUS_IDLE;
         ctrl     <= `ECP_CTRL_RST;
         irq_en   <= `ECP_IRQ_EN_RST;
         irq_st   <= 7'h00;
         cmd      <= ecp_cmd_t'(7'h00);
         wb_dat_o <= 32'h0000_0000;
      end else begin
         bstate   <= next_bstate;
         ctrl     <= next_ctrl;
         irq_en   <= next_irq_en;
         irq_st   <= next_irq_st;
         cmd      <= next_cmd;
         wb_dat_o <= next_dat;
      end
   end

   // Ack straight from the state register; irq is a level of enabled sticky bits
   assign wb_ack_o = (bstate == ECP_BUS_ACK);
   assign cmd_o    = cmd;
   assign irq_o    = |(irq_st & irq_en);

   //----------------------------------------
   // Status outputs
   //----------------------------------------
   // Gated by the enable so a disabled port shows all lines low
   always_comb begin
      next_stat.power_state = enabled & power_on_i;
      next_stat.out_state   = enabled & output_on_i;
      next_stat.limiting    = enabled & (|limiter_act_i);
      next_stat.busy        = enabled & ctrl[`ECP_CTRL_BUSY];
      next_stat.sync0       = enabled & seq_active_i & (seq_sync_i[0] | ctrl[`ECP_CTRL_SYNC0]);
      next_stat.sync1       = enabled & seq_active_i & (seq_sync_i[1] | ctrl[`ECP_CTRL_SYNC1]);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat <= ecp_stat_t'(6'h00);
      end else begin
         stat <= next_stat;
      end
   end

   // Two undefined lines held low
   assign stat_pin_o = {2'h0, stat};

   //----------------------------------------
   // Checks
   //----------------------------------------
   // Commands only from an edge seen while enabled
   a_cmd_needs_en: assert property (@(posedge clk_i) disable iff (rst_i)
      (|cmd) |-> $past(enabled))
      else $error("command while disabled");
   a_cmd_from_fall: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd.out_on |-> $past(fall[1]))
      else $error("output on without edge");
   a_start_fires: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(enabled && fall[2]) |-> cmd.seq_start)
      else $error("start edge lost");
   a_cmd_sets_st: assert property (@(posedge clk_i) disable iff (rst_i)
      (|cmd) |-> ((irq_st & cmd) == cmd))
      else $error("status bit not set");

   // A held-low pin must not repeat its command
   a_fall_one_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      fall[0] |=> !fall[0])
      else $error("edge pulse repeats");
   a_stop_single: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd.seq_stop |=> !cmd.seq_stop)
      else $error("stop pulse repeats");

   // Status lines track their sources one cycle late, dark while disabled
   a_lim_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      ($past(enabled) && $past(|limiter_act_i)) |-> stat.limiting)
      else $error("limiter line missed");
   a_lim_release: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(|limiter_act_i) |-> !stat.limiting)
      else $error("limiter line stuck");
   a_stat_off_dis: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(enabled) |-> (stat_pin_o == 8'h00))
      else $error("status while disabled");
   a_power_state: assert property (@(posedge clk_i) disable iff (rst_i)
      stat.power_state == $past(enabled && power_on_i))
      else $error("power line wrong");
   a_out_state: assert property (@(posedge clk_i) disable iff (rst_i)
      stat.out_state == $past(enabled && output_on_i))
      else $error("output line wrong");
   a_busy_line: assert property (@(posedge clk_i) disable iff (rst_i)
      stat.busy == $past(enabled && ctrl[`ECP_CTRL_BUSY]))
      else $error("busy line wrong");
   a_sync_needs_seq: assert property (@(posedge clk_i) disable iff (rst_i)
      (stat.sync0 || stat.sync1) |-> $past(seq_active_i))
      else $error("sync outside sequence");
   a_sync_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(enabled && seq_active_i && seq_sync_i[0]) |-> stat.sync0)
      else $error("sync line missed");
   a_upper_low: assert property (@(posedge clk_i) disable iff (rst_i)
      stat_pin_o[7:6] == 2'h0)
      else $error("undefined lines driven");

   // Bus answer only to a request, and for one cycle
   a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
endmodule : ecp_io_port

//--- ecp_pkg.sv
package ecp_pkg;
   // Commands decoded from the input lines, bit order as pins 11 to 17
   typedef struct packed {
      logic branch1;
      logic branch0;
      logic seq_hold;
      logic seq_stop;
      logic seq_start;
      logic out_on;
      logic out_off;
   } ecp_cmd_t;
   // Device state shown on the status lines
   typedef struct packed {
      logic sync1;
      logic sync0;
      logic busy;
      logic limiting;
      logic out_state;
      logic power_state;
   } ecp_stat_t;
   typedef enum logic [1:0] {
      ECP_BUS_IDLE,
      ECP_BUS_ACK
   } ecp_bus_state_t;
endpackage : ecp_pkg

//--- tb_ecp_io_port.sv
`timescale 1ns/10ps
`include "ecp_cfg.svh"
module tb_ecp_io_port
   import ecp_pkg::*;
;
   logic        clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, pwr = 0, outs = 0, seq = 0;
   logic [4:0]  adr = 5'h00;
   logic [3:0]  lim = 4'h0;
   logic [1:0]  sync = 2'h0;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic        ack, irq;
   logic [6:0]  pins, ev_val;
   logic [7:0]  stat;
   ecp_cmd_t    cmd;
   int          errors = 0, tests_run = 0, n_ev = 0, cnt = 0, ev_at = 0, t0, e0;

   always #10 clk_i = ~clk_i;
   // Event monitor: count pulses and remember when and which
   always @(posedge clk_i) begin
      cnt <= cnt + 1;
      if (cmd !== 7'h00) begin
         n_ev <= n_ev + 1;
         ev_at <= cnt;
         ev_val <= cmd;
      end
   end

   ecp_ctrl_model i_ecp_ctrl_model (.clk_i(clk_i), .pin_o(pins));
   ecp_io_port i_ecp_io_port (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_ack_o(ack), .irq_o(irq), .cmd_pin_i(pins), .stat_pin_o(stat), .power_on_i(pwr),
      .output_on_i(outs), .limiter_act_i(lim), .seq_active_i(seq), .seq_sync_i(sync),
      .cmd_o(cmd));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t: got %h want %h", $time, got, exp);
      end
   endtask : check

   task automatic conclude;
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude

   // Classic cycle; the wait for ack is bounded
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      if (k >= 20) begin
         errors++;
         conclude();
      end
      rd = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   // One command edge; checks count, timing and which line
   task automatic fire(input int i, input int lowc, input logic en);
      e0 = n_ev;
      t0 = cnt;
      i_ecp_ctrl_model.strike(i, lowc);
      repeat (3) @(posedge clk_i);
      check(n_ev - e0, en);
      if (en) check(ev_at - t0, 5);
      if (en) check(ev_val, 7'h01 << i);
   endtask : fire

   //---------------------------------------------
   // Main sequence
   //---------------------------------------------
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(0, `ECP_OFF_CTRL, 0); check(rd, `ECP_CTRL_RST);
      wb(0, `ECP_OFF_IRQ_CLR, 0); check(rd, 0);
      // Disabled: status dark, edges ignored
      pwr <= 1'b1;
      fire(2, 3, 0);
      check(stat, 8'h00);
      wb(0, `ECP_OFF_IRQ_ST, 0); check(rd, 0);
      wb(1, `ECP_OFF_STATE, 32'hff); wb(0, `ECP_OFF_STATE, 0); check(rd, 0);
      wb(1, `ECP_OFF_CTRL, 32'h1);
      // Each limiter alone lifts the limiter line
      for (int j = 0; j < 4; j++) begin
         lim <= 4'h1 << j;
         repeat (3) @(posedge clk_i);
         check(stat, 8'h05);
      end
      lim <= 4'h0; outs <= 1'b1; seq <= 1'b1; sync <= 2'h1;
      wb(1, `ECP_OFF_CTRL, 32'h3);
      repeat (2) @(posedge clk_i);
      check(stat, 8'h1b);
      // Forced sync1 shows only while a sequence runs
      wb(1, `ECP_OFF_CTRL, 32'hb);
      repeat (2) @(posedge clk_i);
      check(stat, 8'h3b);
      seq <= 1'b0;
      repeat (2) @(posedge clk_i);
      check(stat, 8'h0b);
      // Every command, interrupt masked on even ones
      for (int i = 0; i < 7; i++) begin
         wb(1, `ECP_OFF_IRQ_EN, i[0] ? 32'h7f : 32'h0);
         wb(0, `ECP_OFF_IRQ_EN, 0); check(rd, i[0] ? 32'h7f : 32'h0);
         fire(i, (i == 3) ? 12 : 3, 1);
         wb(0, `ECP_OFF_IRQ_ST, 0); check(rd, 32'h1 << i);
         check(irq, i[0]);
         wb(1, `ECP_OFF_IRQ_CLR, 32'h1 << i);
         check(irq, 1'b0);
      end
      wb(1, `ECP_OFF_CTRL, 32'h0);
      repeat (2) @(posedge clk_i);
      check(stat, 8'h00);
      conclude();
   end
endmodule : tb_ecp_io_port
